// File: hdl/gpptm_map.vh
// register map, field positions and reset values for the paired gpio ports
// assumes: included by the port block; APB word addressing, 32-bit data
`ifndef GPPTM_MAP_VH
`define GPPTM_MAP_VH

// ==========================================================
// second port (documented offsets from its base)
`define GPPTM_OFS_I_VALUE 12'h000
`define GPPTM_OFS_I_DRIVE 12'h004
`define GPPTM_OFS_I_FUNC 12'h008
`define GPPTM_OFS_RESERVED 12'h010
`define GPPTM_OFS_I_PULLUP 12'h02c
`define GPPTM_OFS_I_INGATE 12'h038

// ==========================================================
// first port (offsets chosen for this block, data register omitted)
`define GPPTM_OFS_H_DRIVE 12'h104
`define GPPTM_OFS_H_FUNC 12'h108
`define GPPTM_OFS_H_PULLUP 12'h12c
`define GPPTM_OFS_H_INGATE 12'h138

// ==========================================================
// widths and reset values
`define GPPTM_PORT_W 8
`define GPPTM_ADDR_W 12
`define GPPTM_RST_ZERO 8'h00
`define GPPTM_RST_H_PULLUP 8'h01
// second port pins that may carry a timer output; pins 7..6 are capture inputs
`define GPPTM_TMR_OUT_PINS 8'h3f

`endif

// File: hdl/gpptm_port_pair.v
// two 8-bit gpio ports with per-bit drive, input gate, pull-up and function select
// assumes: APB master on I_CLK; pads resolve level from data, enable and pull-up
// limitation: the first port keeps no data bits, so an enabled driver drives zero
// hazard: pad inputs pass two flops, so a read lags the pad by two cycles
`timescale 1ns/100ps
`include "gpptm_map.vh"

module gpptm_port_pair (
	// clock and reset
	input wire I_CLK,
	input wire I_RST_B,
	// apb slave
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [11:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	output reg [31:0] O_PRDATA,
	// first port pads
	input wire [7:0] I_H_PIN,
	output wire [7:0] O_H_PIN,
	output wire [7:0] O_H_PIN_OE,
	output wire [7:0] O_H_PULLUP,
	// second port pads
	input wire [7:0] I_I_PIN,
	output wire [7:0] O_I_PIN,
	output wire [7:0] O_I_PIN_OE,
	output wire [7:0] O_I_PULLUP,
	// timer side: captures from first port
	output wire [7:0] O_H_CAPTURE,
	// timer side: second port timer outputs (pins 5..0) and capture (pins 7..6)
	input wire [5:0] I_I_TIMER_OUT,
	output wire [1:0] O_I_CAPTURE,
	// pin inputs seen by software-side logic
	output wire [7:0] O_H_PIN_IN,
	output wire [7:0] O_I_PIN_IN
);

	// ==========================================================
	// register state
	reg [7:0] h_drive;
	reg [7:0] h_func;
	reg [7:0] h_pullup;
	reg [7:0] h_ingate;
	reg [7:0] i_value;
	reg [7:0] i_drive;
	reg [7:0] i_func;
	reg [7:0] i_pullup;
	reg [7:0] i_ingate;
	reg [7:0] h_sync1;
	reg [7:0] h_sync2;
	reg [7:0] i_sync1;
	reg [7:0] i_sync2;
	reg [7:0] i_tmr_q;
	reg hit;
	wire wr_en;
	wire rd_en;
	wire [7:0] wbyte;
	wire [7:0] i_gated;
	wire [7:0] h_gated;
	wire [7:0] i_drive_src;
	// write strobes, one per implemented register
	wire wr_h_drive;
	wire wr_h_func;
	wire wr_h_pullup;
	wire wr_h_ingate;
	wire wr_i_value;
	wire wr_i_drive;
	wire wr_i_func;
	wire wr_i_pullup;
	wire wr_i_ingate;
	// read path and timer output selection
	reg [31:0] next_prdata;
	wire [7:0] i_value_rd;
	wire [7:0] i_tmr_sel;

	// ==========================================================
	// bus decode: zero wait states, every access completes at once
	assign O_PREADY = 1'b1;
	// unassigned or reserved offsets answer with an error rather than silent data
	assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
	assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
	assign rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;
	assign wbyte = I_PWDATA[7:0];

	// address hit table
	always @* begin
		case (I_PADDR)
			`GPPTM_OFS_I_VALUE, `GPPTM_OFS_I_DRIVE, `GPPTM_OFS_I_FUNC: hit = 1'b1;
			`GPPTM_OFS_I_PULLUP, `GPPTM_OFS_I_INGATE: hit = 1'b1;
			`GPPTM_OFS_H_DRIVE, `GPPTM_OFS_H_FUNC: hit = 1'b1;
			`GPPTM_OFS_H_PULLUP, `GPPTM_OFS_H_INGATE: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// ==========================================================
	// write strobes; a write lands only at the access-phase edge
	assign wr_i_value = wr_en & (I_PADDR == `GPPTM_OFS_I_VALUE);
	assign wr_i_drive = wr_en & (I_PADDR == `GPPTM_OFS_I_DRIVE);
	assign wr_i_func = wr_en & (I_PADDR == `GPPTM_OFS_I_FUNC);
	assign wr_i_pullup = wr_en & (I_PADDR == `GPPTM_OFS_I_PULLUP);
	assign wr_i_ingate = wr_en & (I_PADDR == `GPPTM_OFS_I_INGATE);
	assign wr_h_drive = wr_en & (I_PADDR == `GPPTM_OFS_H_DRIVE);
	assign wr_h_func = wr_en & (I_PADDR == `GPPTM_OFS_H_FUNC);
	assign wr_h_pullup = wr_en & (I_PADDR == `GPPTM_OFS_H_PULLUP);
	assign wr_h_ingate = wr_en & (I_PADDR == `GPPTM_OFS_H_INGATE);

	// ==========================================================
	// register writes; only the low byte is stored, upper bits dropped
	// one process per register keeps each reset value beside its load
	// second port value bits
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_value <= `GPPTM_RST_ZERO;
		end else if (wr_i_value) begin
			i_value <= wbyte;
		end
	end

	// second port drive enables
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_drive <= `GPPTM_RST_ZERO;
		end else if (wr_i_drive) begin
			i_drive <= wbyte;
		end
	end

	// second port function select
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_func <= `GPPTM_RST_ZERO;
		end else if (wr_i_func) begin
			i_func <= wbyte;
		end
	end

	// second port pull-ups
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_pullup <= `GPPTM_RST_ZERO;
		end else if (wr_i_pullup) begin
			i_pullup <= wbyte;
		end
	end

	// second port input gates
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_ingate <= `GPPTM_RST_ZERO;
		end else if (wr_i_ingate) begin
			i_ingate <= wbyte;
		end
	end

	// first port drive enables
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_drive <= `GPPTM_RST_ZERO;
		end else if (wr_h_drive) begin
			h_drive <= wbyte;
		end
	end

	// first port function select
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_func <= `GPPTM_RST_ZERO;
		end else if (wr_h_func) begin
			h_func <= wbyte;
		end
	end

	// first port pull-ups; pin 0 comes up pulled high
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_pullup <= `GPPTM_RST_H_PULLUP;
		end else if (wr_h_pullup) begin
			h_pullup <= wbyte;
		end
	end

	// first port input gates
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_ingate <= `GPPTM_RST_ZERO;
		end else if (wr_h_ingate) begin
			h_ingate <= wbyte;
		end
	end

	// ==========================================================
	// value register reads its value bits on driven pins, ORed with the gated pin level
	assign i_value_rd = (i_value & i_drive) | i_gated;
	// read mux; unmapped offsets read zero, never stale data
	always @* begin
		next_prdata = 32'h00000000;
		case (I_PADDR)
			`GPPTM_OFS_I_VALUE: next_prdata = {24'h000000, i_value_rd};
			`GPPTM_OFS_I_DRIVE: next_prdata = {24'h000000, i_drive};
			`GPPTM_OFS_I_FUNC: next_prdata = {24'h000000, i_func};
			`GPPTM_OFS_I_PULLUP: next_prdata = {24'h000000, i_pullup};
			`GPPTM_OFS_I_INGATE: next_prdata = {24'h000000, i_ingate};
			`GPPTM_OFS_H_DRIVE: next_prdata = {24'h000000, h_drive};
			`GPPTM_OFS_H_FUNC: next_prdata = {24'h000000, h_func};
			`GPPTM_OFS_H_PULLUP: next_prdata = {24'h000000, h_pullup};
			`GPPTM_OFS_H_INGATE: next_prdata = {24'h000000, h_ingate};
			default: next_prdata = 32'h00000000;
		endcase
	end

	// read data is latched in the setup cycle so it is a flop at the access edge
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			O_PRDATA <= 32'h00000000;
		end else if (rd_en) begin
			O_PRDATA <= next_prdata;
		end
	end

	// ==========================================================
	// two-flop synchronisers on the pad inputs, then gating by input enable
	// only the second flop is read, so a metastable first stage never spreads
	// first port pads
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			h_sync1 <= 8'h00;
			h_sync2 <= 8'h00;
		end else begin
			h_sync1 <= I_H_PIN;
			h_sync2 <= h_sync1;
		end
	end

	// second port pads
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_sync1 <= 8'h00;
			i_sync2 <= 8'h00;
		end else begin
			i_sync1 <= I_I_PIN;
			i_sync2 <= i_sync1;
		end
	end

	// timer outputs registered so pad data comes from flops
	always @(posedge I_CLK) begin
		if (!I_RST_B) begin
			i_tmr_q <= 8'h00;
		end else begin
			i_tmr_q <= {2'b00, I_I_TIMER_OUT};
		end
	end

	// ==========================================================
	// per-pin muxing; blocked inputs read as zero so floating pads cost nothing
	// pins 7..6 are capture inputs, so their function bit never takes the driver
	assign i_tmr_sel = i_func & `GPPTM_TMR_OUT_PINS;
	genvar g;
	generate
		for (g = 0; g < `GPPTM_PORT_W; g = g + 1) begin : pin
			assign h_gated[g] = h_sync2[g] & h_ingate[g];
			assign i_gated[g] = i_sync2[g] & i_ingate[g];
			// first port pins have no timer output; driver follows its enable bit
			assign O_H_PIN_OE[g] = h_drive[g];
			assign O_H_PIN[g] = 1'b0;
			assign O_H_PULLUP[g] = h_pullup[g];
			// capture routing, bit by bit, when the function bit is one:
			// pin 7 timer3_capture_in1, pin 6 timer3_capture_in0
			// pin 5 timer2_capture_in1, pin 4 timer2_capture_in0
			// pin 3 timer1_capture_in1, pin 2 timer1_capture_in0
			// pin 1 timer0_capture_in1, pin 0 timer0_capture_in0
			assign O_H_CAPTURE[g] = h_gated[g] & h_func[g];
			// function 1 on pins 5..0 drives the timer output instead of the value bit
			assign i_drive_src[g] = i_tmr_sel[g] ? i_tmr_q[g] : i_value[g];
			assign O_I_PIN[g] = i_drive_src[g];
			assign O_I_PIN_OE[g] = i_drive[g];
			assign O_I_PULLUP[g] = i_pullup[g];
		end
	endgenerate

	// second port pins 7..6 are capture inputs of a timer when selected
	assign O_I_CAPTURE = i_gated[7:6] & i_func[7:6];
	assign O_H_PIN_IN = h_gated;
	assign O_I_PIN_IN = i_gated;

endmodule

// File: test/gpptm_asserts.sv
// checker for the paired gpio port block, bound to its top module
// assumes: single clock, synchronous active-low reset, zero-wait apb
`timescale 1ns/100ps
module gpptm_chk (
	input wire I_CLK, input wire I_RST_B,
	input wire I_PSEL, input wire I_PENABLE, input wire I_PWRITE,
	input wire [11:0] I_PADDR, input wire [31:0] I_PWDATA,
	input wire O_PSLVERR, input wire [31:0] O_PRDATA,
	input wire [7:0] O_I_PIN_OE, input wire [7:0] O_H_PIN_OE,
	input wire [7:0] O_I_PULLUP, input wire [7:0] O_H_PULLUP,
	input wire [7:0] O_H_CAPTURE, input wire [7:0] O_H_PIN_IN
);
	// =====
	// access decode, used by every property except a_reset_vals and a_capture_gated
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	wire acc = I_PSEL && I_PENABLE;
	wire wr = acc && I_PWRITE;
	a_idrive_write: assert property (wr && I_PADDR == 12'h004 |=> O_I_PIN_OE == $past(I_PWDATA[7:0]))
		else $error("drive enable not loaded");
	a_hdrive_write: assert property (wr && I_PADDR == 12'h104 |=> O_H_PIN_OE == $past(I_PWDATA[7:0]))
		else $error("first drive enable not loaded");
	a_pullup_write: assert property (wr && I_PADDR == 12'h12c |=> O_H_PULLUP == $past(I_PWDATA[7:0]))
		else $error("pull-up not loaded");
	a_drive_hold: assert property (!(wr && I_PADDR == 12'h004) |=> $stable(O_I_PIN_OE))
		else $error("drive enable moved unasked");
	a_reset_vals: assert property ($rose(I_RST_B) |-> O_H_PULLUP == 8'h01
		&& O_I_PULLUP == 8'h00 && O_I_PIN_OE == 8'h00 && O_H_PIN_OE == 8'h00)
		else $error("bad reset state");
	a_reserved_err: assert property (acc && I_PADDR == 12'h010 |-> O_PSLVERR)
		else $error("reserved offset accepted");
	a_mapped_ok: assert property (acc && I_PADDR == 12'h02c |-> !O_PSLVERR)
		else $error("mapped offset refused");
	a_upper_zero: assert property (acc && !I_PWRITE |-> O_PRDATA[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_capture_gated: assert property ((O_H_CAPTURE & ~O_H_PIN_IN) == 8'h00)
		else $error("capture without input path");
endmodule
bind gpptm_port_pair gpptm_chk u_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
	.O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA), .O_I_PIN_OE(O_I_PIN_OE),
	.O_H_PIN_OE(O_H_PIN_OE), .O_I_PULLUP(O_I_PULLUP), .O_H_PULLUP(O_H_PULLUP),
	.O_H_CAPTURE(O_H_CAPTURE), .O_H_PIN_IN(O_H_PIN_IN));

// File: test/gpptm_board.sv
// board model of one 8-pin pad row
// assumes: board drives only pins whose driver is off
`timescale 1ns/100ps
module gpptm_board (
	input wire clk,
	input wire [7:0] drv, oe, pu, ext, ext_en,
	output reg [7:0] pad
);
	// =====
	// a floating pin toggles so no stale level reads as valid
	reg [7:0] flt = 8'h00;
	integer i;
	always @(posedge clk) flt <= ~flt;
	always @* for (i = 0; i < 8; i++) pad[i] = oe[i] ? drv[i] : ext_en[i] ? ext[i] : pu[i] | flt[i];
endmodule

// File: test/tb.sv
// testbench for the paired gpio ports over apb
// assumes: zero-wait slave, two-flop pin synchronisers
`timescale 1ns/100ps
module tb;
	reg clk, rst_b, psel, pen, pwr, e;
	reg [11:0] pa;
	reg [31:0] pwd, r;
	reg [7:0] h_ext, h_en, i_ext, i_en;
	wire [1:0] i_cap;
	wire [7:0] i_in;
	reg [5:0] tmr;
	reg [11:0] adr [0:8];
	integer mismatches, checked, k;
	wire rdy, err;
	wire [31:0] prd;
	wire [7:0] h_pin, h_oe, h_pu, h_pad, i_pin, i_oe, i_pu, i_pad, h_cap, h_in;
	gpptm_port_pair i_dut (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PREADY(rdy), .O_PSLVERR(err),
		.O_PRDATA(prd), .I_H_PIN(h_pad), .O_H_PIN(h_pin), .O_H_PIN_OE(h_oe), .O_H_PULLUP(h_pu),
		.I_I_PIN(i_pad), .O_I_PIN(i_pin), .O_I_PIN_OE(i_oe), .O_I_PULLUP(i_pu),
		.O_H_CAPTURE(h_cap), .I_I_TIMER_OUT(tmr), .O_I_CAPTURE(i_cap), .O_H_PIN_IN(h_in),
		.O_I_PIN_IN(i_in));
	gpptm_board u_hb (.clk(clk), .drv(h_pin), .oe(h_oe), .pu(h_pu), .ext(h_ext), .ext_en(h_en),
		.pad(h_pad));
	gpptm_board u_ib (.clk(clk), .drv(i_pin), .oe(i_oe), .pu(i_pu), .ext(i_ext), .ext_en(i_en),
		.pad(i_pad));
	// =====
	// compare, verdict and one apb transfer
	task check(input [31:0] seen, input [31:0] exp);
		checked = checked + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		integer n;
		n = 0;
		psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
		@(posedge clk) pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1) begin
			n = n + 1;
			if (n > 20) begin
				mismatches = mismatches + 1;
				conclude;
			end
			@(posedge clk);
		end
		r = prd; e = err; psel <= 1'b0; pen <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// =====
	// main sequence
	initial begin
		mismatches = 0; checked = 0; rst_b = 0; psel = 0; pen = 0; pwr = 0; pa = 0; pwd = 0;
		h_ext = 0; h_en = 0; tmr = 0; i_ext = 0; i_en = 0;
		adr = '{12'h000, 12'h004, 12'h008, 12'h02c, 12'h038, 12'h104, 12'h108, 12'h12c, 12'h138};
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 9; k++) begin
			xfer(0, adr[k], 0);
			check(r, adr[k] == 12'h12c ? 32'h1 : 32'h0);
		end
		for (k = 0; k < 9; k++) xfer(1, adr[k], 32'hffffffa5);
		for (k = 0; k < 9; k++) begin
			xfer(0, adr[k], 0);
			check(r, 32'ha5);
		end
		// reserved place: refused, reads zero, drive register untouched
		xfer(1, 12'h010, 32'hff);
		xfer(0, 12'h010, 0);
		check(r, 0);
		check(e, 1);
		xfer(0, 12'h004, 0);
		check(r, 32'ha5);
		xfer(1, 12'h104, 0); xfer(1, 12'h108, 32'hff); xfer(1, 12'h138, 32'hff);
		h_ext <= 8'h96; h_en <= 8'hff;
		repeat (4) @(posedge clk);
		check(h_cap, 8'h96);
		check(h_in, 8'h96);
		xfer(1, 12'h138, 0);
		repeat (4) @(posedge clk);
		check(h_in | h_cap, 8'h00);
		tmr <= 6'h2a;
		xfer(1, 12'h008, 32'h3f); xfer(1, 12'h004, 32'h3f);
		repeat (2) @(posedge clk);
		check(i_pin, 8'haa);
		check(h_pin, 8'h00);
		check(h_pu, 8'ha5);
		check(i_pu, 8'ha5);
		// pins 7..6 as capture inputs while pins 5..0 stay on the timer
		i_ext <= 8'h80; i_en <= 8'hc0;
		xfer(1, 12'h008, 32'hff); xfer(1, 12'h038, 32'hff);
		repeat (4) @(posedge clk);
		check(i_cap, 2'b10);
		check(i_in, 8'haa);
		// mid-run reset brings the pull-up and drive registers back to their reset values
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		xfer(0, 12'h12c, 0);
		check(r, 32'h1);
		xfer(0, 12'h004, 0);
		check(r, 32'h0);
		check(i_oe | h_oe, 8'h00);
		conclude;
	end
endmodule
